// [logic/imr_defs.svh]
// Offsets, field positions, reset values and constants of the interrupt mask block.
`ifndef IMR_DEFS_SVH
`define IMR_DEFS_SVH

// Register indices; the byte address is four times the index.
`define IMR_IDX_CONV_MASK    16'h401C
`define IMR_IDX_PIN_MASK     16'h401D
`define IMR_IDX_WRITE_TALLY  16'h4020
`define IMR_IDX_TIME_UPPER   16'h4021
`define IMR_IDX_TIME_LOWER   16'h4022
`define IMR_IDX_CONV_STATUS  16'h4040
`define IMR_IDX_PIN_STATUS   16'h4041

// Field positions in the converter event mask and status registers.
`define IMR_BIT_HIGHCUR_CONV2    9
`define IMR_BIT_HIGHCUR_CONV1    8
`define IMR_BIT_OSC_STARTUP      7
`define IMR_BIT_UNDERVOLT_CONV4  3
`define IMR_BIT_UNDERVOLT_CONV3  2
`define IMR_BIT_UNDERVOLT_CONV2  1
`define IMR_BIT_UNDERVOLT_CONV1  0

// Field positions in the pin event mask and status registers.
`define IMR_BIT_PIN12_EVENT  11
`define IMR_BIT_PIN1_EVENT   0

// Implemented bits of each register pair; all other bits read as zero.
`define IMR_CONV_IMPL    16'h038F
`define IMR_PIN_IMPL     16'h0FFF

// Reset values: every implemented mask bit starts out masked.
`define IMR_CONV_MASK_RST   16'h038F
`define IMR_PIN_MASK_RST    16'h0FFF
`define IMR_STATUS_RST      16'h0000
`define IMR_TALLY_RST       16'h0000
`define IMR_TIME_RST        16'h0000

// Pseudo-random generator feeding the write tally.
`define IMR_LFSR_TAPS  16'hB400
`define IMR_LFSR_SEED  16'hACE1

`endif

// [logic/imr_pkg.sv]
// Types shared by the interrupt mask block.
package imr_pkg;

  // One 16-bit register word.
  typedef logic [15:0] imr_word_t;

  // Register selected by a decoded bus address.
  typedef enum logic [2:0] {
    IMR_SEL_NONE        = 3'h0,
    IMR_SEL_CONV_MASK   = 3'h1,
    IMR_SEL_PIN_MASK    = 3'h2,
    IMR_SEL_WRITE_TALLY = 3'h3,
    IMR_SEL_TIME_UPPER  = 3'h4,
    IMR_SEL_TIME_LOWER  = 3'h5,
    IMR_SEL_CONV_STATUS = 3'h6,
    IMR_SEL_PIN_STATUS  = 3'h7
  } imr_sel_t;

endpackage : imr_pkg

// [logic/imr_lfsr.sv]
// Free-running Galois shift register that supplies pseudo-random words.
`timescale 1ns/1ps
`include "imr_defs.svh"

module imr_lfsr #(
  parameter int             WIDTH = 16,
  parameter logic [WIDTH-1:0] TAPS  = `IMR_LFSR_TAPS,
  parameter logic [WIDTH-1:0] SEED  = `IMR_LFSR_SEED
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  output logic      [WIDTH-1:0] rand_word
);

  logic [WIDTH-1:0] state_r;
  logic [WIDTH-1:0] state_nxt;

  // Shift right and fold the feedback taps in when the low bit falls out.
  always_comb begin
    state_nxt = {1'b0, state_r[WIDTH-1:1]};
    if (state_r[0]) begin
      state_nxt = state_nxt ^ TAPS;
    end
  end

  // The seed is non-zero so the register never locks up.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_r <= SEED;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rand_word = state_r;

endmodule : imr_lfsr

// [logic/imr_top.sv]
// Interrupt mask, status and clock write tally registers behind an APB slave.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "imr_defs.svh"

module imr_top #(
  parameter int ADDR_W = 18,
  parameter int PIN_N  = 12
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [15:0]       conv_event_in,
  input  wire logic [PIN_N-1:0]  pin_event_in,
  output logic      [31:0]       time_seconds,
  output logic                   irq
);

  localparam int IDX_W = ADDR_W - 2;

  imr_pkg::imr_word_t conv_mask_r;
  imr_pkg::imr_word_t pin_mask_r;
  imr_pkg::imr_word_t conv_status_r;
  imr_pkg::imr_word_t pin_status_r;
  imr_pkg::imr_word_t tally_r;
  imr_pkg::imr_word_t time_upper_r;
  imr_pkg::imr_word_t time_lower_r;
  imr_pkg::imr_word_t conv_events;
  imr_pkg::imr_word_t pin_events;
  imr_pkg::imr_word_t conv_clear;
  imr_pkg::imr_word_t pin_clear;
  imr_pkg::imr_word_t wr_word;
  imr_pkg::imr_word_t wr_lanes;
  imr_pkg::imr_word_t rd_word;
  imr_pkg::imr_word_t rand_word;
  imr_pkg::imr_sel_t  sel;
  logic [IDX_W-1:0]   idx;
  logic               setup_phase;
  logic               wr_commit;
  logic               time_write;
  logic [31:0]        prdata_r;
  logic               pready_r;
  logic               pslverr_r;
  logic               irq_r;
  logic [31:0]        time_r;

  // Random source for the clock write tally.
  imr_lfsr #(
    .WIDTH (16),
    .TAPS  (`IMR_LFSR_TAPS),
    .SEED  (`IMR_LFSR_SEED)
  ) u_lfsr (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .rand_word (rand_word)
  );

  // Word index from the aligned byte address; the two low address bits are ignored.
  assign idx = paddr[ADDR_W-1:2];

  // Address decode into a register select.
  always_comb begin
    case (idx)
      IDX_W'(`IMR_IDX_CONV_MASK):   sel = imr_pkg::IMR_SEL_CONV_MASK;
      IDX_W'(`IMR_IDX_PIN_MASK):    sel = imr_pkg::IMR_SEL_PIN_MASK;
      IDX_W'(`IMR_IDX_WRITE_TALLY): sel = imr_pkg::IMR_SEL_WRITE_TALLY;
      IDX_W'(`IMR_IDX_TIME_UPPER):  sel = imr_pkg::IMR_SEL_TIME_UPPER;
      IDX_W'(`IMR_IDX_TIME_LOWER):  sel = imr_pkg::IMR_SEL_TIME_LOWER;
      IDX_W'(`IMR_IDX_CONV_STATUS): sel = imr_pkg::IMR_SEL_CONV_STATUS;
      IDX_W'(`IMR_IDX_PIN_STATUS):  sel = imr_pkg::IMR_SEL_PIN_STATUS;
      default:                      sel = imr_pkg::IMR_SEL_NONE;
    endcase
  end

  // Setup phase starts an access; the write lands at the edge that completes it.
  assign setup_phase = psel && !penable;
  assign wr_commit   = psel && penable && pready_r && pwrite && !pslverr_r;

  // Byte lanes pick which halves of the low word a write replaces.
  assign wr_lanes = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // Merge the written bytes into a word.
  function automatic imr_pkg::imr_word_t merge_lanes(
    input imr_pkg::imr_word_t old_word,
    input imr_pkg::imr_word_t new_word,
    input imr_pkg::imr_word_t lanes
  );
    merge_lanes = (old_word & ~lanes) | (new_word & lanes);
  endfunction : merge_lanes

  assign wr_word = pwdata[15:0];

  // Read multiplexer; unimplemented bits and the upper half read as zero.
  always_comb begin
    case (sel)
      imr_pkg::IMR_SEL_CONV_MASK:   rd_word = conv_mask_r;
      imr_pkg::IMR_SEL_PIN_MASK:    rd_word = pin_mask_r;
      imr_pkg::IMR_SEL_WRITE_TALLY: rd_word = tally_r;
      imr_pkg::IMR_SEL_TIME_UPPER:  rd_word = time_upper_r;
      imr_pkg::IMR_SEL_TIME_LOWER:  rd_word = time_lower_r;
      imr_pkg::IMR_SEL_CONV_STATUS: rd_word = conv_status_r;
      imr_pkg::IMR_SEL_PIN_STATUS:  rd_word = pin_status_r;
      default:                      rd_word = `IMR_STATUS_RST;
    endcase
  end

  // Bus answer: ready one cycle after setup, error for an unmapped address.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_phase;
      pslverr_r <= setup_phase && (sel == imr_pkg::IMR_SEL_NONE);
      if (setup_phase && !pwrite) begin
        prdata_r <= {16'h0000, rd_word};
      end
    end
  end

  // Mask registers; only implemented bits are writable and all start masked.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      conv_mask_r <= `IMR_CONV_MASK_RST;
      pin_mask_r  <= `IMR_PIN_MASK_RST;
    end else if (wr_commit) begin
      if (sel == imr_pkg::IMR_SEL_CONV_MASK) begin
        conv_mask_r <= merge_lanes(conv_mask_r, wr_word, wr_lanes) & `IMR_CONV_IMPL;
      end
      if (sel == imr_pkg::IMR_SEL_PIN_MASK) begin
        pin_mask_r <= merge_lanes(pin_mask_r, wr_word, wr_lanes) & `IMR_PIN_IMPL;
      end
    end
  end

  // Event vectors placed at the documented field positions.
  always_comb begin
    conv_events = `IMR_STATUS_RST;
    conv_events[`IMR_BIT_HIGHCUR_CONV2]   = conv_event_in[`IMR_BIT_HIGHCUR_CONV2];
    conv_events[`IMR_BIT_HIGHCUR_CONV1]   = conv_event_in[`IMR_BIT_HIGHCUR_CONV1];
    conv_events[`IMR_BIT_OSC_STARTUP]     = conv_event_in[`IMR_BIT_OSC_STARTUP];
    conv_events[`IMR_BIT_UNDERVOLT_CONV4] = conv_event_in[`IMR_BIT_UNDERVOLT_CONV4];
    conv_events[`IMR_BIT_UNDERVOLT_CONV3] = conv_event_in[`IMR_BIT_UNDERVOLT_CONV3];
    conv_events[`IMR_BIT_UNDERVOLT_CONV2] = conv_event_in[`IMR_BIT_UNDERVOLT_CONV2];
    conv_events[`IMR_BIT_UNDERVOLT_CONV1] = conv_event_in[`IMR_BIT_UNDERVOLT_CONV1];
    pin_events = `IMR_STATUS_RST;
    pin_events[PIN_N-1:0] = pin_event_in;
    pin_events = pin_events & `IMR_PIN_IMPL;
  end

  // Write-one-to-clear strobes for the status registers.
  always_comb begin
    conv_clear = `IMR_STATUS_RST;
    pin_clear  = `IMR_STATUS_RST;
    if (wr_commit && sel == imr_pkg::IMR_SEL_CONV_STATUS) begin
      conv_clear = wr_word & wr_lanes;
    end
    if (wr_commit && sel == imr_pkg::IMR_SEL_PIN_STATUS) begin
      pin_clear = wr_word & wr_lanes;
    end
  end

  // Sticky status bits record every event, masked or not; a set beats a clear.
  for (genvar b = 0; b < 16; b++) begin : g_status
    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        conv_status_r[b] <= 1'b0;
        pin_status_r[b]  <= 1'b0;
      end else begin
        conv_status_r[b] <= conv_events[b] || (conv_status_r[b] && !conv_clear[b]);
        pin_status_r[b]  <= pin_events[b] || (pin_status_r[b] && !pin_clear[b]);
      end
    end
  end

  // Interrupt line is high while a pending bit has its mask clear.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(conv_status_r & ~conv_mask_r) || |(pin_status_r & ~pin_mask_r);
    end
  end

  // Either half of the seconds count being written counts as a time write.
  assign time_write = wr_commit && (sel == imr_pkg::IMR_SEL_TIME_UPPER ||
                                    sel == imr_pkg::IMR_SEL_TIME_LOWER);

  // Seconds count halves, upper half at the lower index.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      time_upper_r <= `IMR_TIME_RST;
      time_lower_r <= `IMR_TIME_RST;
    end else if (wr_commit) begin
      if (sel == imr_pkg::IMR_SEL_TIME_UPPER) begin
        time_upper_r <= merge_lanes(time_upper_r, wr_word, wr_lanes);
      end
      if (sel == imr_pkg::IMR_SEL_TIME_LOWER) begin
        time_lower_r <= merge_lanes(time_lower_r, wr_word, wr_lanes);
      end
    end
  end

  // Tally takes a fresh pseudo-random value on every time write.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tally_r <= `IMR_TALLY_RST;
    end else if (time_write) begin
      tally_r <= rand_word;
    end
  end

  // The full seconds value is offered to the time keeping logic from a flop.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      time_r <= 32'h0000_0000;
    end else begin
      time_r <= {time_upper_r, time_lower_r};
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign irq          = irq_r;
  assign time_seconds = time_r;

endmodule : imr_top

// [tb/imr_checker.sv]
// Concurrent checks on the ports of the interrupt mask block.
`timescale 1ns/1ps
`include "imr_defs.svh"
module imr_checker #(
  parameter int ADDR_W = 18,
  parameter int PIN_N  = 12
) (
  input wire logic              ref_clk,
  input wire logic              resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [15:0]       conv_event_in,
  input wire logic [PIN_N-1:0]  pin_event_in,
  input wire logic [31:0]       time_seconds,
  input wire logic              irq
);
  logic hit;
  logic wr_done;
  logic evt;
  // Decoded words, committed writes and any incoming event.
  assign hit = {paddr[ADDR_W-1:2], 2'b00} inside {`IMR_IDX_CONV_MASK*4, `IMR_IDX_PIN_MASK*4,
    `IMR_IDX_WRITE_TALLY*4, `IMR_IDX_TIME_UPPER*4, `IMR_IDX_TIME_LOWER*4,
    `IMR_IDX_CONV_STATUS*4, `IMR_IDX_PIN_STATUS*4};
  assign wr_done = psel && penable && pready && pwrite;
  assign evt = (conv_event_in != 16'h0000) || (pin_event_in != '0);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready && (pslverr == !$past(hit)))
    else $error("ready or error response wrong after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  a_rdata_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_irq_quiet_reset: assert property ($rose(resetn) |-> (!irq) [*3])
    else $error("interrupt raised right after reset");
  a_irq_rise_cause: assert property ($rose(irq) |-> $past(wr_done, 2) || $past(evt, 2))
    else $error("interrupt rose without event or write");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_done, 2))
    else $error("interrupt fell without a write");
  a_time_write_only: assert property ($changed(time_seconds) |-> $past(wr_done, 2))
    else $error("seconds changed without a write");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pready && pslverr);
  c_time: cover property ($changed(time_seconds));
endmodule : imr_checker

bind imr_top imr_checker #(.ADDR_W(ADDR_W), .PIN_N(PIN_N)) imr_checker_inst (
  .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .conv_event_in(conv_event_in), .pin_event_in(pin_event_in),
  .time_seconds(time_seconds), .irq(irq));

// [tb/imr_host_model.sv]
// Host-side model that counts the interrupt requests it services.
`timescale 1ns/1ps
module imr_host_model (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       irq,
  output logic      [7:0] irq_count
);
  logic irq_r;
  // Each rising edge of the level request is one service call.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      irq_r     <= 1'b0;
      irq_count <= 8'h00;
    end else begin
      irq_r <= irq;
      if (irq && !irq_r) irq_count <= irq_count + 8'h01;
    end
  end
endmodule : imr_host_model

// [tb/imr_top_tb.sv]
// Self-checking bench for the interrupt mask block.
`timescale 1ns/1ps
`include "imr_defs.svh"
module imr_top_tb;
  localparam logic [17:0] A_CM = 18'(`IMR_IDX_CONV_MASK * 4);
  localparam logic [17:0] A_PM = 18'(`IMR_IDX_PIN_MASK * 4);
  localparam logic [17:0] A_CS = 18'(`IMR_IDX_CONV_STATUS * 4);
  localparam logic [17:0] A_PS = 18'(`IMR_IDX_PIN_STATUS * 4);
  localparam logic [17:0] A_TY = 18'(`IMR_IDX_WRITE_TALLY * 4);
  logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, er;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, time_seconds, rd, t0;
  logic [3:0]  pstrb = 4'hF;
  logic [15:0] conv_event_in = '0;
  logic [11:0] pin_event_in = '0;
  logic [7:0]  irq_count;
  int mismatches = 0, tests_run = 0, cyc = 0;
  imr_top imr_top_inst (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_event_in(conv_event_in),
    .pin_event_in(pin_event_in), .time_seconds(time_seconds), .irq(irq));
  imr_host_model imr_host_model_inst (.ref_clk(ref_clk), .resetn(resetn), .irq(irq),
    .irq_count(irq_count));
  // Clock at 40 MHz and a watchdog on the run length.
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; setup, then access until ready is sampled high.
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle
  // Reset values, writable bits and the error answer of an unmapped address.
  task automatic t_reset();
    apb(0, A_CM, 0);
    chk("conv mask", rd, `IMR_CONV_MASK_RST);
    apb(0, A_PM, 0);
    chk("pin mask", rd, `IMR_PIN_MASK_RST);
    apb(1, A_CM, 32'h0000FC70);
    apb(0, A_CM, 0);
    chk("conv bits clear", rd, 32'h00000000);
    apb(1, A_CM, 32'h0000FFFF);
    apb(0, A_CM, 0);
    chk("conv bits", rd, `IMR_CONV_IMPL);
    apb(0, 18'h10090, 0);
    chk("unmapped err", er, 1);
    chk("unmapped data", rd, 0);
  endtask : t_reset
  // One source: masked event records only, unmask raises, clear drops.
  task automatic t_src(input logic pn, input int b);
    logic [15:0] m;
    logic [15:0] im;
    m = 16'h0001 << b;
    im = pn ? `IMR_PIN_IMPL : `IMR_CONV_IMPL;
    @(posedge ref_clk);
    conv_event_in <= pn ? 16'h0000 : m;
    pin_event_in <= pn ? m[11:0] : 12'h000;
    @(posedge ref_clk);
    conv_event_in <= 16'h0000;
    pin_event_in <= 12'h000;
    settle(2);
    chk("masked irq", irq, 0);
    apb(0, pn ? A_PS : A_CS, 0);
    chk("status", rd, m);
    apb(1, pn ? A_PM : A_CM, {16'h0000, ~m});
    settle(1);
    chk("unmasked irq", irq, 1);
    apb(0, pn ? A_PM : A_CM, 0);
    chk("mask", rd, ~m & im);
    apb(1, pn ? A_PS : A_CS, m);
    settle(1);
    chk("cleared irq", irq, 0);
    apb(0, pn ? A_PS : A_CS, 0);
    chk("status cleared", rd, 0);
    apb(1, pn ? A_PM : A_CM, 32'h0000FFFF);
  endtask : t_src
  // Time writes reload the tally; byte strobes pick the written half of a word.
  task automatic t_time();
    apb(1, A_TY + 18'h4, 32'h00001234);
    apb(0, A_TY, 0);
    t0 = rd;
    chk("tally loaded", rd == 32'h0, 0);
    apb(1, A_TY, 32'h00005555);
    apb(0, A_TY, 0);
    chk("tally read only", rd, t0);
    apb(1, A_TY + 18'h8, 32'h0000ABCD);
    apb(0, A_TY, 0);
    chk("tally reloaded", rd == t0, 0);
    chk("seconds", time_seconds, 32'h1234ABCD);
    pstrb <= 4'h2;
    apb(1, A_TY + 18'h8, 32'h00005A00);
    pstrb <= 4'hF;
    settle(1);
    chk("seconds lane", time_seconds, 32'h12345ACD);
  endtask : t_time
  // A reset in mid-run puts cleared masks back to fully masked.
  task automatic t_rst2();
    apb(1, A_CM, 32'h00000000);
    apb(1, A_PM, 32'h00000000);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    apb(0, A_CM, 0);
    chk("conv mask again", rd, `IMR_CONV_MASK_RST);
    apb(0, A_PM, 0);
    chk("pin mask again", rd, `IMR_PIN_MASK_RST);
    chk("seconds reset", time_seconds, 32'h00000000);
  endtask : t_rst2
  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Reset, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    for (int b = 0; b < 16; b++) begin
      if (`IMR_CONV_IMPL >> b & 1) begin
        t_src(0, b);
      end
    end
    for (int b = 0; b < 12; b++) begin
      t_src(1, b);
    end
    chk("irq services", irq_count, 8'h13);
    t_time();
    t_rst2();
    wrap_up();
  end
endmodule : imr_top_tb
